// ### design/nps_pkg.sv
// package of the power state manager: states, modes, timing counts
// assumes a 25 mhz system clock
package nps_pkg;

  // ****************************************
  // power states and modes
  // ****************************************
  typedef enum logic [1:0] {
    NPS_ST_MONITOR,
    NPS_ST_HPD,
    NPS_ST_STANDBY,
    NPS_ST_ACTIVE
  } nps_state_e;

  typedef enum logic [1:0] {
    NPS_FM_IDLE,
    NPS_FM_TARGET,
    NPS_FM_INITIATOR
  } nps_func_e;

  // ****************************************
  // widths, reset values and timing
  // ****************************************
  localparam int NPS_LVL_W = 8;
  localparam logic [NPS_LVL_W-1:0] NPS_CRIT_RST = 8'h40;
  localparam logic [NPS_LVL_W-1:0] NPS_HYST_RST = 8'h08;
  localparam int NPS_CLK_HZ = 25_000_000;
  localparam int NPS_BOOT_US = 100;
  localparam int NPS_BOOT_CYC = (NPS_BOOT_US * (NPS_CLK_HZ / 1_000_000));
  localparam int NPS_CNT_W = 24;
  localparam int NPS_POLL_ACT_CYC = 256;
  localparam int NPS_POLL_SBY_CYC = 1024;

endpackage : nps_pkg

// ### design/nps_sync.sv
// two-flop synchroniser bank for asynchronous pin levels
// assumes one clock domain; first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module nps_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : nps_sync
`default_nettype wire

// ### design/nps_power_state_manager.sv
// power mode and power state manager of the contactless controller
// assumes pins are asynchronous; battery level arrives as a sampled code
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - system mode is full power only with battery present and power enable high, else power off.
// - power off allows no communication mode; full power allows reader, card and peer modes.
// - monitor is entered when enabled, battery below critical level and power enable high.
// - battery above critical level with power enable low holds hard power down.
// - standby keeps a minimum powered and wakes to active on an enabled wake source.
// - active powers all blocks and runs idle, target or initiator mode.
// - the polling loop cycles autonomously between active and standby.
// - the host selects functional states and may restrict functionality.
// - power enable low forces hard power down and holds it there.
// - host commands reach the block through the nci command decoder port.
// - monitor is left for active only when battery rises above critical level plus hysteresis or monitor is disabled.
// - a dedicated interrupt output with programmable polarity signals data flow.
module nps_power_state_manager
  import nps_pkg::*;
#(
  parameter int BOOT_CYC = nps_pkg::NPS_BOOT_CYC,
  parameter int POLL_ACT = nps_pkg::NPS_POLL_ACT_CYC,
  parameter int POLL_SBY = nps_pkg::NPS_POLL_SBY_CYC
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // supply pins (asynchronous)
  input  wire logic                          battery_present,
  input  wire logic                          power_enable_pin,
  input  wire logic [nps_pkg::NPS_LVL_W-1:0] battery_level,
  // configuration
  input  wire logic                          monitor_en,
  input  wire logic [nps_pkg::NPS_LVL_W-1:0] crit_level,
  input  wire logic [nps_pkg::NPS_LVL_W-1:0] crit_hyst,
  input  wire logic                          wake_rf_en,
  input  wire logic                          wake_host_en,
  // wake sources (asynchronous)
  input  wire logic                          rf_field_det,
  input  wire logic                          host_if_wake,
  // host commands from nci decoder
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire nps_pkg::nps_func_e            cmd_func,
  input  wire logic                          cmd_standby,
  input  wire logic                          cmd_poll_en,
  input  wire logic [2:0]                    cmd_allow,
  input  wire logic                          irq_req,
  input  wire logic                          irq_active_high,
  // status and control
  output var  nps_pkg::nps_state_e           state,
  output var  nps_pkg::nps_func_e            func_mode,
  output logic                               full_power,
  output logic                               all_blocks_on,
  output logic                               wake_domain_on,
  output logic                               allow_reader,
  output logic                               allow_card,
  output logic                               allow_p2p,
  output var  logic                          boot_busy,
  output var  logic                          irq_out
);
  import nps_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int SW = 4 + NPS_LVL_W;
  logic [SW-1:0] pin_s;

  // one bank for the whole level bus; the source must hold it steady while it moves
  nps_sync #(.W(SW)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({battery_present, power_enable_pin, rf_field_det, host_if_wake, battery_level}),
    .sync_out (pin_s)
  );

  wire logic                 bat_s  = pin_s[SW-1];
  wire logic                 pen_s  = pin_s[SW-2];
  wire logic                 rf_s   = pin_s[SW-3];
  wire logic                 hw_s   = pin_s[SW-4];
  wire logic [NPS_LVL_W-1:0] lvl_s  = pin_s[NPS_LVL_W-1:0];

  // ****************************************
  // decode
  // ****************************************
  // nine-bit exit level so a large hysteresis cannot wrap
  wire logic [NPS_LVL_W:0] exit_sum = {1'b0, crit_level} + {1'b0, crit_hyst};
  wire logic bat_low  = lvl_s < crit_level;
  wire logic bat_ok   = {1'b0, lvl_s} > exit_sum;
  wire logic enter_mon = monitor_en && bat_low && pen_s;
  wire logic wake_hit = (wake_rf_en && rf_s) || (wake_host_en && hw_s);

  nps_state_e nxt_state;
  nps_func_e  nxt_func;
  logic [NPS_CNT_W-1:0] cnt_ff;
  logic [NPS_CNT_W-1:0] nxt_cnt;
  logic                 poll_ff;
  logic [2:0]           allow_ff;
  logic                 irq_ff;

  wire logic cnt_done = (cnt_ff == '0);

  // supply loss outranks every other request, so no command can hold the block up
  wire logic supply_off = !bat_s || !pen_s;
  wire logic cmd_take   = cmd_valid && cmd_ready;
  wire logic poll_wake  = poll_ff && cnt_done;
  // poll standby only from idle, so a running rf exchange is never cut
  wire logic poll_sleep = poll_wake && !boot_busy && (func_mode == NPS_FM_IDLE);
  wire logic boot_start = (state != NPS_ST_ACTIVE) && (state != NPS_ST_STANDBY);
  wire logic boot_hold  = boot_busy && (nxt_cnt != '0);

  // ****************************************
  // helpers
  // ****************************************
  // reload value for the shared down counter
  function automatic logic [NPS_CNT_W-1:0] load_cnt(input int cyc);
    load_cnt = NPS_CNT_W'(cyc);
  endfunction

  // ****************************************
  // state selection
  // ****************************************
  always_comb begin
    nxt_state = state;
    nxt_func  = func_mode;
    nxt_cnt   = cnt_done ? '0 : cnt_ff - 1'b1;
    if (supply_off) begin
      nxt_state = NPS_ST_HPD;
      nxt_func  = NPS_FM_IDLE;
    end else begin
      case (state)
        NPS_ST_HPD: begin
          if (enter_mon) begin
            nxt_state = NPS_ST_MONITOR;
          end else begin
            nxt_state = NPS_ST_ACTIVE;
            nxt_func  = NPS_FM_IDLE;
            nxt_cnt   = load_cnt(BOOT_CYC);
          end
        end
        NPS_ST_MONITOR: begin
          if (!monitor_en || bat_ok) begin
            nxt_state = NPS_ST_ACTIVE;
            nxt_func  = NPS_FM_IDLE;
            nxt_cnt   = load_cnt(BOOT_CYC);
          end
        end
        NPS_ST_STANDBY: begin
          // the standby count doubles as the poll interval
          if (enter_mon) begin
            nxt_state = NPS_ST_MONITOR;
          end else if (wake_hit || poll_wake) begin
            nxt_state = NPS_ST_ACTIVE;
            nxt_cnt   = load_cnt(POLL_ACT);
          end
        end
        NPS_ST_ACTIVE: begin
          // a weak battery wins over host requests
          if (enter_mon) begin
            nxt_state = NPS_ST_MONITOR;
          end else if (cmd_take) begin
            nxt_func = cmd_func;
            if (cmd_standby) begin
              nxt_state = NPS_ST_STANDBY;
              nxt_cnt   = load_cnt(POLL_SBY);
            end
          end else if (poll_sleep) begin
            nxt_state = NPS_ST_STANDBY;
            nxt_cnt   = load_cnt(POLL_SBY);
          end
        end
        default: nxt_state = NPS_ST_HPD;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= NPS_ST_HPD;
      func_mode <= NPS_FM_IDLE;
      cnt_ff    <= '0;
      boot_busy <= 1'b0;
      poll_ff   <= 1'b0;
      allow_ff  <= 3'h7;
      irq_ff    <= 1'b0;
      irq_out   <= 1'b0;
    end else begin
      state     <= nxt_state;
      func_mode <= nxt_func;
      cnt_ff    <= nxt_cnt;
      // boot ends when the boot count runs out
      boot_busy <= (nxt_state == NPS_ST_ACTIVE) && (boot_start || boot_hold);
      // settings change only on a taken command, never while refused
      if (cmd_take) begin
        poll_ff  <= cmd_poll_en;
        allow_ff <= cmd_allow;
      end
      // polarity applied at the last flop so the pin carries no decode glitch
      irq_ff  <= irq_req && full_power;
      irq_out <= irq_ff ~^ irq_active_high ? 1'b1 : 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // commands only accepted once boot is over
  assign cmd_ready      = (state == NPS_ST_ACTIVE) && !boot_busy;
  assign full_power     = (state == NPS_ST_ACTIVE) || (state == NPS_ST_STANDBY);
  assign all_blocks_on  = (state == NPS_ST_ACTIVE);
  assign wake_domain_on = full_power;
  // power off forces every permission low whatever the host last set
  assign allow_reader   = full_power && allow_ff[0];
  assign allow_card     = full_power && allow_ff[1];
  assign allow_p2p      = full_power && allow_ff[2];

endmodule : nps_power_state_manager
`default_nettype wire

// ### verification/nps_power_state_manager_asserts.sv
// port checks for the power state manager
// assumes the bind below reaches every manager instance
`timescale 1ns/1ps
`default_nettype none
module nps_power_state_manager_asserts
  import nps_pkg::*;
#(
  parameter int BOOT_CYC = 8
) (
  // inputs
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          battery_present,
  input wire logic                          power_enable_pin,
  input wire logic [nps_pkg::NPS_LVL_W-1:0] battery_level,
  input wire logic                          monitor_en,
  input wire logic [nps_pkg::NPS_LVL_W-1:0] crit_level,
  input wire logic [nps_pkg::NPS_LVL_W-1:0] crit_hyst,
  input wire logic                          irq_req,
  input wire logic                          irq_active_high,
  // outputs
  input wire nps_pkg::nps_state_e           state,
  input wire logic                          cmd_ready,
  input wire logic                          full_power,
  input wire logic                          all_blocks_on,
  input wire logic                          allow_reader,
  input wire logic                          allow_card,
  input wire logic                          allow_p2p,
  input wire logic                          boot_busy,
  input wire logic                          irq_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [23:0] bc_ff;
  // boot length; cleared outside boot so an abort starts afresh
  always_ff @(posedge clk or posedge rst) begin
    if (rst) bc_ff <= 24'h0;
    else bc_ff <= boot_busy ? bc_ff + 24'h1 : 24'h0;
  end
  chk_pen_low_hpd: assert property (!power_enable_pin [*3] |=> state == NPS_ST_HPD)
    else $error("pen low without hpd");
  chk_no_battery: assert property (!battery_present [*3] |=> !full_power)
    else $error("full power without battery");
  chk_mode_map: assert property (full_power == (state inside {NPS_ST_STANDBY, NPS_ST_ACTIVE})
    && all_blocks_on == (state == NPS_ST_ACTIVE)) else $error("mode map wrong");
  chk_allow_gate: assert property (!full_power |-> !(allow_reader || allow_card || allow_p2p))
    else $error("comm allowed in power off");
  chk_mon_entry: assert property ((monitor_en && power_enable_pin && battery_present
    && battery_level < crit_level) [*3] |=> state == NPS_ST_MONITOR) else $error("no monitor");
  chk_mon_exit: assert property ((state == NPS_ST_MONITOR && monitor_en
    && {1'b0, battery_level} <= crit_level + crit_hyst) [*3] |=> state != NPS_ST_ACTIVE)
    else $error("monitor left early");
  chk_cmd_gate: assert property (cmd_ready == (state == NPS_ST_ACTIVE && !boot_busy))
    else $error("cmd ready wrong");
  chk_boot_len: assert property ($fell(boot_busy) && state == NPS_ST_ACTIVE
    |-> bc_ff >= BOOT_CYC && bc_ff <= BOOT_CYC + 2) else $error("boot length wrong");
  chk_irq_lag: assert property (irq_active_high && $past(irq_active_high)
    && $past(irq_active_high, 2) |-> irq_out == ($past(irq_req, 2) && $past(full_power, 2)))
    else $error("irq out wrong");
endmodule // nps_power_state_manager_asserts
bind nps_power_state_manager nps_power_state_manager_asserts #(.BOOT_CYC(BOOT_CYC)) u_chk (
  .clk(clk), .rst(rst), .battery_present(battery_present), .power_enable_pin(power_enable_pin),
  .battery_level(battery_level), .monitor_en(monitor_en), .crit_level(crit_level),
  .crit_hyst(crit_hyst), .irq_req(irq_req), .irq_active_high(irq_active_high), .state(state),
  .cmd_ready(cmd_ready), .full_power(full_power), .all_blocks_on(all_blocks_on),
  .allow_reader(allow_reader), .allow_card(allow_card), .allow_p2p(allow_p2p),
  .boot_busy(boot_busy), .irq_out(irq_out));
`default_nettype wire

// ### verification/nps_host_model.sv
// host side model: power enable pin and command handshake
// assumes the bench calls its tasks; drives just after falling edges
`timescale 1ns/1ps
`default_nettype none
module nps_host_model
  import nps_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                cmd_ready,
  output var  logic                power_enable_pin,
  output var  logic                cmd_valid,
  output var  nps_pkg::nps_func_e  cmd_func,
  output var  logic                cmd_standby,
  output var  logic                cmd_poll_en,
  output var  logic [2:0]          cmd_allow
);
  initial begin
    cmd_func = NPS_FM_IDLE;
    {power_enable_pin, cmd_valid, cmd_standby, cmd_poll_en, cmd_allow} = 7'h00;
  end
  task automatic set_pen(input logic v);
    @(negedge clk);
    power_enable_pin = v;
  endtask
  // request held until ready is sampled high
  task automatic send(input nps_func_e f, input logic [4:0] sp);
    @(negedge clk);
    {cmd_valid, cmd_standby, cmd_poll_en, cmd_allow} = {1'b1, sp};
    cmd_func = f;
    // ready is settled at the falling edge; the next rising edge takes it
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
endmodule // nps_host_model
`default_nettype wire

// ### verification/tb_nps_power_state_manager.sv
// self-checking bench for the power state manager
// assumes short boot and poll counts; host model drives pen and commands
`timescale 1ns/1ps
`default_nettype none
module tb_nps_power_state_manager;
  import nps_pkg::*;
  logic clk = 1'b0, rst = 1'b1, bat = 1'b1, mon = 1'b0, rf = 1'b0, irq = 1'b0, pol = 1'b1;
  logic wre = 1'b1, whe = 1'b1, hwk = 1'b0;
  logic [7:0] lvl = 8'h80, crit = 8'h40, hyst = 8'h08;
  logic pen, vld, rdy, sby, pl, fp, blk, wdo, rd, cd, pp, busy, iro;
  logic [2:0] alw;
  nps_func_e fn, fm;
  nps_state_e st;
  int failures = 0, n_checks = 0;
  always #20 clk = ~clk;
  nps_power_state_manager #(.BOOT_CYC(8), .POLL_ACT(8), .POLL_SBY(16)) dut (
    .clk(clk), .rst(rst), .battery_present(bat), .power_enable_pin(pen), .battery_level(lvl),
    .monitor_en(mon), .crit_level(crit), .crit_hyst(hyst), .wake_rf_en(wre),
    .wake_host_en(whe), .rf_field_det(rf), .host_if_wake(hwk), .cmd_valid(vld),
    .cmd_ready(rdy), .cmd_func(fn), .cmd_standby(sby), .cmd_poll_en(pl), .cmd_allow(alw),
    .irq_req(irq), .irq_active_high(pol), .state(st), .func_mode(fm), .full_power(fp),
    .all_blocks_on(blk), .wake_domain_on(wdo), .allow_reader(rd), .allow_card(cd),
    .allow_p2p(pp), .boot_busy(busy), .irq_out(iro));
  nps_host_model host (.clk(clk), .cmd_ready(rdy), .power_enable_pin(pen), .cmd_valid(vld),
    .cmd_func(fn), .cmd_standby(sby), .cmd_poll_en(pl), .cmd_allow(alw));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait, then compare
  task automatic wait_st(input nps_state_e s, input int lim);
    repeat (lim) if (st !== s) @(negedge clk);
    chk(st, s);
  endtask
  task automatic t_boot;
    host.set_pen(1'b1);
    wait_st(NPS_ST_ACTIVE, 6);
    chk({busy, rdy, rd, cd, pp}, 8'h17);
    repeat (10) @(negedge clk);
    chk({busy, rdy, fm}, {2'b01, NPS_FM_IDLE});
  endtask
  task automatic t_cmd;
    host.send(NPS_FM_TARGET, 5'b00010);
    chk({fm, rd, cd, pp}, {NPS_FM_TARGET, 3'b010});
    host.send(NPS_FM_INITIATOR, 5'b00101);
    chk({fm, rd, cd, pp}, {NPS_FM_INITIATOR, 3'b101});
  endtask
  task automatic t_sby;
    host.send(NPS_FM_IDLE, 5'b10111);
    chk({st, fp, blk}, {NPS_ST_STANDBY, 2'b10});
    rf = 1'b1;
    wait_st(NPS_ST_ACTIVE, 5);
    rf = 1'b0;
    chk({busy, rdy, blk}, 8'h03);
  endtask
  task automatic t_irq;
    irq = 1'b1;
    repeat (3) @(negedge clk);
    chk(iro, 1'b1);
    pol = 1'b0;
    repeat (3) @(negedge clk);
    chk(iro, 1'b0);
    irq = 1'b0;
    repeat (3) @(negedge clk);
    chk(iro, 1'b1);
    pol = 1'b1;
  endtask
  // disabled sources are ignored, an enabled one wakes at once
  task automatic t_wake;
    {wre, whe} = 2'b00;
    host.send(NPS_FM_IDLE, 5'b10111);
    chk({st, wdo}, {NPS_ST_STANDBY, 1'b1});
    {rf, hwk} = 2'b11;
    repeat (6) @(negedge clk);
    chk(st, NPS_ST_STANDBY);
    whe = 1'b1;
    wait_st(NPS_ST_ACTIVE, 3);
    {rf, hwk, wre} = 3'b001;
    chk({fp, blk, wdo, busy}, 8'h0e);
  endtask
  // mid-run reset, then the first edges after its release
  task automatic t_rst;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk({st, fm, fp, busy, rdy, iro}, {NPS_ST_HPD, NPS_FM_IDLE, 4'h0});
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk({st, rdy}, {NPS_ST_HPD, 1'b0});
    @(negedge clk);
    chk({st, busy, rdy}, {NPS_ST_ACTIVE, 2'b10});
  endtask
  // per threshold set: just below entry, at the exit boundary, one above it
  task automatic mon_round(input logic [7:0] c, input logic [7:0] h);
    {crit, hyst, lvl} = {c, h, c - 8'h01};
    wait_st(NPS_ST_MONITOR, 5);
    chk({fp, rd, wdo}, 8'h00);
    lvl = c + h;
    repeat (6) @(negedge clk);
    chk(st, NPS_ST_MONITOR);
    lvl = c + h + 8'h01;
    wait_st(NPS_ST_ACTIVE, 5);
    chk(busy, 1'b1);
  endtask
  task automatic t_mon;
    mon = 1'b1;
    mon_round(8'h40, 8'h08);
    mon_round(8'h20, 8'h10);
  endtask
  task automatic t_off;
    host.set_pen(1'b0);
    wait_st(NPS_ST_HPD, 5);
    chk({fp, rd, cd, pp, rdy, wdo}, 8'h00);
    host.set_pen(1'b1);
    wait_st(NPS_ST_ACTIVE, 6);
    bat = 1'b0;
    wait_st(NPS_ST_HPD, 5);
    chk(fp, 1'b0);
  endtask
  task automatic t_poll;
    bat = 1'b1;
    host.send(NPS_FM_IDLE, 5'b01111);
    wait_st(NPS_ST_STANDBY, 12);
    wait_st(NPS_ST_ACTIVE, 20);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_boot;
    t_cmd;
    t_sby;
    t_wake;
    t_irq;
    t_rst;
    t_mon;
    t_off;
    t_poll;
    conclude;
  end
  initial begin
    #200000;
    failures++;
    conclude;
  end
endmodule // tb_nps_power_state_manager
`default_nettype wire
